// ### pulse_meter_pkg.sv
// register map, field positions and timing constants of the pulse rate meter
package pulse_meter_pkg;
  // register byte offsets
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_UPPER_PRESET = 6'h04;
  localparam logic [5:0] ADDR_LOWER_PRESET = 6'h08;
  localparam logic [5:0] ADDR_LOAD = 6'h0c;
  localparam logic [5:0] ADDR_MEASURED = 6'h10;
  localparam logic [5:0] ADDR_STATUS = 6'h14;
  localparam logic [5:0] ADDR_UPPER_ACTIVE = 6'h18;
  localparam logic [5:0] ADDR_LOWER_ACTIVE = 6'h1c;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h20;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h24;
  // field positions
  localparam int CTRL_SEL_LSB = 0;
  localparam int LOAD_UPPER_BIT = 0;
  localparam int LOAD_LOWER_BIT = 1;
  localparam int ST_ABOVE_BIT = 0;
  localparam int ST_BELOW_BIT = 1;
  localparam int ST_VALID_BIT = 2;
  localparam int ST_RUN_BIT = 3;
  localparam int ST_TIMING_BIT = 4;
  localparam int IRQ_UPPER_BIT = 0;
  localparam int IRQ_LOWER_BIT = 1;
  // sample time selector codes
  localparam logic [2:0] SEL_1MS = 3'h0;
  localparam logic [2:0] SEL_2MS = 3'h1;
  localparam logic [2:0] SEL_4MS = 3'h2;
  localparam logic [2:0] SEL_100MS = 3'h3;
  localparam logic [2:0] SEL_1S = 3'h4;
  localparam logic [2:0] SEL_10S = 3'h5;
  // reset values
  localparam logic [2:0] SEL_RESET = SEL_1S;
  localparam logic [31:0] UPPER_RESET = 32'h7fffffff;
  localparam logic [31:0] LOWER_RESET = 32'h00000000;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [31:0] INVALID_VALUE = 32'hffffffff;
  localparam logic [31:0] SAT_VALUE = 32'h7fffffff;
  // clock and sample times
  localparam int CLK_MHZ = 125;
  localparam longint CLK_HZ = 125000000;
  localparam int T_1MS_US = 1000;
  localparam int T_2MS_US = 2000;
  localparam int T_4MS_US = 4000;
  localparam int T_100MS_US = 100000;
  localparam int T_1S_US = 1000000;
  localparam int T_10S_US = 10000000;
  localparam int WIN_1MS_CYC = T_1MS_US * CLK_MHZ;
  localparam int WIN_2MS_CYC = T_2MS_US * CLK_MHZ;
  localparam int WIN_4MS_CYC = T_4MS_US * CLK_MHZ;
  localparam int WIN_100MS_CYC = T_100MS_US * CLK_MHZ;
  localparam int WIN_1S_CYC = T_1S_US * CLK_MHZ;
  localparam int WIN_10S_CYC = T_10S_US * CLK_MHZ;
  // longest edge interval still resolved (20 mHz)
  localparam longint ZERO_LIMIT_MS = 50000;
  localparam longint ZERO_LIMIT_CYC = ZERO_LIMIT_MS * CLK_HZ / 1000;
  // result unit is mHz: edges scaled per window, reciprocal numerator
  localparam logic [31:0] MULT_100MS = 32'h00002710;
  localparam logic [31:0] MULT_1S = 32'h000003e8;
  localparam logic [31:0] MULT_10S = 32'h00000064;
  localparam longint RECIP_NUM = 1000 * CLK_HZ;
  localparam int DIV_STEPS = 47;
  typedef enum logic {DIV_IDLE, DIV_RUN} div_state_t;
endpackage

// ### pulse_rate_meter.sv
// pulse rate meter with threshold comparators and avalon-mm registers
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module pulse_rate_meter #(
  parameter int WIN_1MS_CYC = pulse_meter_pkg::WIN_1MS_CYC,
  parameter int WIN_2MS_CYC = pulse_meter_pkg::WIN_2MS_CYC,
  parameter int WIN_4MS_CYC = pulse_meter_pkg::WIN_4MS_CYC,
  parameter int WIN_100MS_CYC = pulse_meter_pkg::WIN_100MS_CYC,
  parameter int WIN_1S_CYC = pulse_meter_pkg::WIN_1S_CYC,
  parameter int WIN_10S_CYC = pulse_meter_pkg::WIN_10S_CYC,
  parameter longint ZERO_LIMIT_CYC = pulse_meter_pkg::ZERO_LIMIT_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic meas_in,
  input wire logic host_running,
  output logic upper_exceeded,
  output logic lower_undershot,
  output logic irq
);
  localparam logic [33:0] ZLIM = 34'(ZERO_LIMIT_CYC);
  localparam logic [46:0] NUM = 47'(pulse_meter_pkg::RECIP_NUM);

  // window length in cycles for a selector code
  function automatic logic [30:0] win_len(input logic [2:0] sel);
    case (sel)
      pulse_meter_pkg::SEL_1MS: win_len = 31'(WIN_1MS_CYC);
      pulse_meter_pkg::SEL_2MS: win_len = 31'(WIN_2MS_CYC);
      pulse_meter_pkg::SEL_4MS: win_len = 31'(WIN_4MS_CYC);
      pulse_meter_pkg::SEL_100MS: win_len = 31'(WIN_100MS_CYC);
      pulse_meter_pkg::SEL_10S: win_len = 31'(WIN_10S_CYC);
      default: win_len = 31'(WIN_1S_CYC);
    endcase
  endfunction

  // edge count to mHz scale for the counting windows
  function automatic logic [31:0] count_mult(input logic [2:0] sel);
    case (sel)
      pulse_meter_pkg::SEL_100MS: count_mult = pulse_meter_pkg::MULT_100MS;
      pulse_meter_pkg::SEL_10S: count_mult = pulse_meter_pkg::MULT_10S;
      default: count_mult = pulse_meter_pkg::MULT_1S;
    endcase
  endfunction

  logic [2:0] sel_reg;
  logic [31:0] upper_preset_reg;
  logic [31:0] lower_preset_reg;
  logic [1:0] load_reg;
  logic [1:0] load_prev_reg;
  logic [31:0] upper_active_reg;
  logic [31:0] lower_active_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic wait_reg;
  logic [31:0] readdata_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic level_reg;
  logic run_prev_reg;
  logic [30:0] win_cnt_reg;
  logic [31:0] edge_cnt_reg;
  logic [31:0] measured_frequency_reg;
  logic valid_reg;
  logic seen_reg;
  logic [33:0] period_cnt_reg;
  logic tpend_reg;
  logic [31:0] tval_reg;
  pulse_meter_pkg::div_state_t div_state_reg;
  logic [5:0] div_cnt_reg;
  logic [34:0] div_rem_reg;
  logic [46:0] div_quo_reg;
  logic [33:0] div_den_reg;
  logic above_reg;
  logic below_reg;
  logic irq_reg;

  // bus decode and access strobes
  wire take_wr = write && !wait_reg;
  wire take_rd = read && wait_reg;
  wire wr_ctrl = take_wr && (address == pulse_meter_pkg::ADDR_CTRL);
  wire wr_upper = take_wr && (address == pulse_meter_pkg::ADDR_UPPER_PRESET);
  wire wr_lower = take_wr && (address == pulse_meter_pkg::ADDR_LOWER_PRESET);
  wire wr_load = take_wr && (address == pulse_meter_pkg::ADDR_LOAD);
  wire wr_irq_st = take_wr && (address == pulse_meter_pkg::ADDR_IRQ_STATUS);
  wire wr_irq_mask = take_wr && (address == pulse_meter_pkg::ADDR_IRQ_MASK);

  // mode, run control and window timing
  wire timing_mode = (sel_reg <= pulse_meter_pkg::SEL_4MS);
  wire start = host_running && !run_prev_reg;
  wire running = host_running && !start;
  wire tick = running && (win_cnt_reg >= win_len(sel_reg) - 31'd1);
  wire rise = running && sync2_reg && sync3_reg && !level_reg;

  // reciprocal divider step
  wire [34:0] rem_shift = {div_rem_reg[33:0], div_quo_reg[46]};
  wire div_ge = (rem_shift >= {1'b0, div_den_reg});
  wire [34:0] rem_sub = rem_shift - {1'b0, div_den_reg};
  wire div_done = (div_state_reg == pulse_meter_pkg::DIV_RUN) && (div_cnt_reg == 6'h01);
  wire [46:0] quo_last = {div_quo_reg[45:0], div_ge};
  wire [31:0] quo_sat = (quo_last[46:31] != 16'h0000) ? pulse_meter_pkg::SAT_VALUE
                                                      : quo_last[31:0];
  // an interval at or past the zero limit is never divided, it stays zero
  wire start_div = rise && seen_reg && timing_mode
                   && (period_cnt_reg < ZLIM - 34'd1);
  wire too_slow = running && timing_mode && (period_cnt_reg == ZLIM - 34'd1);

  // new result chosen at the window end, in timing modes the first interval result as soon as it is ready
  wire publish = (tick && (!timing_mode || tpend_reg))
                 || (timing_mode && tpend_reg && !valid_reg);
  wire [31:0] count_val = 32'(edge_cnt_reg * count_mult(sel_reg));
  wire [31:0] pub_val = timing_mode ? tval_reg : count_val;

  // threshold comparison and interrupt events
  wire above_next = valid_reg && (measured_frequency_reg > upper_active_reg);
  wire below_next = valid_reg && (measured_frequency_reg < lower_active_reg);
  wire [1:0] irq_set = {below_next && !below_reg, above_next && !above_reg}
                       & {2{timing_mode && host_running}};
  wire [1:0] irq_clr = wr_irq_st ? writedata[1:0] : 2'h0;
  wire [1:0] load_rise = load_reg & ~load_prev_reg;

  // register read selection
  wire [31:0] status_word = {27'h0, timing_mode, host_running, valid_reg, below_reg, above_reg};
  wire [31:0] rd_mux =
    (address == pulse_meter_pkg::ADDR_CTRL) ? {29'h0, sel_reg} :
    (address == pulse_meter_pkg::ADDR_UPPER_PRESET) ? upper_preset_reg :
    (address == pulse_meter_pkg::ADDR_LOWER_PRESET) ? lower_preset_reg :
    (address == pulse_meter_pkg::ADDR_LOAD) ? {30'h0, load_reg} :
    (address == pulse_meter_pkg::ADDR_MEASURED) ? measured_frequency_reg :
    (address == pulse_meter_pkg::ADDR_STATUS) ? status_word :
    (address == pulse_meter_pkg::ADDR_UPPER_ACTIVE) ? upper_active_reg :
    (address == pulse_meter_pkg::ADDR_LOWER_ACTIVE) ? lower_active_reg :
    (address == pulse_meter_pkg::ADDR_IRQ_STATUS) ? {30'h0, irq_status_reg} :
    (address == pulse_meter_pkg::ADDR_IRQ_MASK) ? {30'h0, irq_mask_reg} : 32'h0;

  // bus handshake: one wait cycle, then answer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wait_reg <= 1'b1;
      readdata_reg <= 32'h0;
    end else begin
      wait_reg <= !((read || write) && wait_reg);
      if (take_rd) begin
        readdata_reg <= rd_mux;
      end
    end
  end

  // software registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sel_reg <= pulse_meter_pkg::SEL_RESET;
      upper_preset_reg <= pulse_meter_pkg::UPPER_RESET;
      lower_preset_reg <= pulse_meter_pkg::LOWER_RESET;
      load_reg <= 2'h0;
      irq_mask_reg <= pulse_meter_pkg::IRQ_MASK_RESET;
    end else begin
      if (wr_ctrl) sel_reg <= writedata[2:0];
      if (wr_upper) upper_preset_reg <= writedata;
      if (wr_lower) lower_preset_reg <= writedata;
      if (wr_load) load_reg <= writedata[1:0];
      if (wr_irq_mask) irq_mask_reg <= writedata[1:0];
    end
  end

  // threshold loading on strobe edges
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      load_prev_reg <= 2'h0;
      upper_active_reg <= pulse_meter_pkg::UPPER_RESET;
      lower_active_reg <= pulse_meter_pkg::LOWER_RESET;
    end else begin
      load_prev_reg <= load_reg;
      if (load_rise[pulse_meter_pkg::LOAD_UPPER_BIT]) upper_active_reg <= upper_preset_reg;
      if (load_rise[pulse_meter_pkg::LOAD_LOWER_BIT]) lower_active_reg <= lower_preset_reg;
    end
  end

  // input synchroniser and qualified level
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      sync1_reg <= meas_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg) level_reg <= sync2_reg;
    end
  end

  // window counter and edge counter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_prev_reg <= 1'b0;
      win_cnt_reg <= 31'h0;
      edge_cnt_reg <= 32'h0;
    end else begin
      run_prev_reg <= host_running;
      if (start || tick) begin
        win_cnt_reg <= 31'h0;
        edge_cnt_reg <= {31'h0, rise && tick};
      end else if (running) begin
        win_cnt_reg <= win_cnt_reg + 31'd1;
        edge_cnt_reg <= edge_cnt_reg + {31'h0, rise};
      end
    end
  end

  // interval timing between rising edges
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seen_reg <= 1'b0;
      period_cnt_reg <= 34'h0;
      tpend_reg <= 1'b0;
      tval_reg <= 32'h0;
    end else if (start) begin
      seen_reg <= 1'b0;
      period_cnt_reg <= 34'h0;
      tpend_reg <= 1'b0;
    end else if (running) begin
      if (rise) begin
        seen_reg <= 1'b1;
        period_cnt_reg <= 34'h0;
      end else if (period_cnt_reg < ZLIM) begin
        period_cnt_reg <= period_cnt_reg + 34'd1;
      end
      if (too_slow) begin
        tval_reg <= 32'h0;
        tpend_reg <= 1'b1;
      end else if (div_done) begin
        tval_reg <= quo_sat;
        tpend_reg <= 1'b1;
      end else if (tick) begin
        tpend_reg <= 1'b0;
      end
    end
  end

  // sequential reciprocal divider
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_state_reg <= pulse_meter_pkg::DIV_IDLE;
      div_cnt_reg <= 6'h0;
      div_rem_reg <= 35'h0;
      div_quo_reg <= 47'h0;
      div_den_reg <= 34'h1;
    end else begin
      case (div_state_reg)
        pulse_meter_pkg::DIV_IDLE: begin
          if (start_div) begin
            div_state_reg <= pulse_meter_pkg::DIV_RUN;
            div_cnt_reg <= 6'(pulse_meter_pkg::DIV_STEPS);
            div_rem_reg <= 35'h0;
            div_quo_reg <= NUM;
            div_den_reg <= period_cnt_reg + 34'd1;
          end
        end
        pulse_meter_pkg::DIV_RUN: begin
          div_rem_reg <= div_ge ? rem_sub : rem_shift;
          div_quo_reg <= quo_last;
          div_cnt_reg <= div_cnt_reg - 6'd1;
          if (div_done || start) div_state_reg <= pulse_meter_pkg::DIV_IDLE;
        end
        default: div_state_reg <= pulse_meter_pkg::DIV_IDLE;
      endcase
    end
  end

  // published result, held outside running
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      measured_frequency_reg <= pulse_meter_pkg::INVALID_VALUE;
      valid_reg <= 1'b0;
    end else if (start) begin
      measured_frequency_reg <= pulse_meter_pkg::INVALID_VALUE;
      valid_reg <= 1'b0;
    end else if (publish) begin
      measured_frequency_reg <= pub_val;
      valid_reg <= 1'b1;
    end
  end

  // comparator flags, sticky interrupt bits and output
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      above_reg <= 1'b0;
      below_reg <= 1'b0;
      irq_status_reg <= 2'h0;
      irq_reg <= 1'b0;
    end else begin
      above_reg <= above_next;
      below_reg <= below_next;
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
      irq_reg <= |(((irq_status_reg & ~irq_clr) | irq_set) & irq_mask_reg);
    end
  end

  assign readdata = readdata_reg;
  assign waitrequest = wait_reg;
  assign upper_exceeded = above_reg;
  assign lower_undershot = below_reg;
  assign irq = irq_reg;
endmodule

// ### pulse_rate_meter_sva.sv
// port checker of the pulse rate meter
`timescale 1ns/1ps
module pulse_rate_meter_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic host_running,
  input wire logic upper_exceeded,
  input wire logic lower_undershot,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic seen_run_reg;
  // remembers a running phase since reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seen_run_reg <= 1'b0;
    end else if (host_running) begin
      seen_run_reg <= 1'b1;
    end
  end
  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  sequence s_ans;
    !waitrequest ##1 waitrequest;
  endsequence
  sequence s_quiet;
    !host_running && !$past(host_running) && !write && !$past(write);
  endsequence
  AST_ANSWER: assert property (s_req |=> s_ans)
    else $error("bus answer missing");
  AST_NO_REQ: assert property (!(read || write) && waitrequest |=> waitrequest)
    else $error("answer without request");
  AST_RDATA_HOLD: assert property (!read |=> $stable(readdata))
    else $error("read data moved");
  AST_FLAG_IDLE: assert property (!seen_run_reg |-> !upper_exceeded && !lower_undershot)
    else $error("flag before first value");
  AST_RESET: assert property (disable iff (1'b0) rst |=> !irq && !upper_exceeded && waitrequest)
    else $error("outputs active after reset");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(write) || $past(write, 2))
    else $error("irq dropped without write");
  AST_IRQ_RISE: assert property ($rose(irq) |->
    $past(write, 2) || $rose(upper_exceeded) || $rose(lower_undershot))
    else $error("irq without crossing");
  AST_STOP_HOLD: assert property (s_quiet |=> $stable({upper_exceeded, lower_undershot}))
    else $error("flags moved while stopped");
endmodule

bind pulse_rate_meter pulse_rate_meter_chk chk (.ref_clk(ref_clk), .rst(rst), .read(read),
  .write(write), .readdata(readdata), .waitrequest(waitrequest), .host_running(host_running),
  .upper_exceeded(upper_exceeded), .lower_undershot(lower_undershot), .irq(irq));

// ### pulse_source.sv
// pulse source standing in for the external sensor
`timescale 1ns/1ps
module pulse_source (
  input wire logic ref_clk,
  input wire logic run,
  input wire logic [31:0] half,
  output logic meas_in
);
  int cnt = 0;
  initial meas_in = 1'b0;
  // low while stopped, square wave of two half periods while running
  always @(posedge ref_clk) begin
    if (!run) begin
      meas_in <= 1'b0;
      cnt <= 0;
    end else if (cnt >= half - 1) begin
      cnt <= 0;
      meas_in <= ~meas_in;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ### tb_pulse_rate_meter.sv
// self-checking bench of the pulse rate meter
`timescale 1ns/1ps
module tb_pulse_rate_meter;
  // shortened windows and zero limit so every mode fits the run
  localparam int MS1_CYC = 200;
  localparam int MS2_CYC = 300;
  localparam int MS4_CYC = 400;
  localparam int MS100_CYC = 1000;
  localparam int S1_CYC = 2000;
  localparam int S10_CYC = 5000;
  localparam int ZLIM_CYC = 20000;
  int wins[6] = '{MS1_CYC, MS2_CYC, MS4_CYC, MS100_CYC, S1_CYC, S10_CYC};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic host_running = 1'b0;
  logic src_run = 1'b0;
  logic [31:0] src_half = 32'h0000000a;
  logic [31:0] readdata;
  logic waitrequest;
  logic meas_in;
  logic upper_exceeded;
  logic lower_undershot;
  logic irq;
  logic [31:0] seed = 32'h00000062;
  logic [31:0] rd;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  int t_run = 0;
  longint exp_q[$];
  pulse_rate_meter #(.WIN_1MS_CYC(MS1_CYC), .WIN_2MS_CYC(MS2_CYC), .WIN_4MS_CYC(MS4_CYC),
    .WIN_100MS_CYC(MS100_CYC), .WIN_1S_CYC(S1_CYC), .WIN_10S_CYC(S10_CYC),
    .ZERO_LIMIT_CYC(ZLIM_CYC)) DUT (
    .ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .meas_in(meas_in),
    .host_running(host_running), .upper_exceeded(upper_exceeded),
    .lower_undershot(lower_undershot), .irq(irq));
  pulse_source src (.ref_clk(ref_clk), .run(src_run), .half(src_half), .meas_in(meas_in));
  // clock and cycle count
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // reference result in mHz from edge count or interval
  function automatic longint model(input int sel, input longint edges, input longint ivl);
    longint r;
    case (sel)
      3: r = edges * 10000;
      4: r = edges * 1000;
      5: r = edges * 100;
      default: r = (ivl >= ZLIM_CYC) ? 0 : 1000 * pulse_meter_pkg::CLK_HZ / ivl;
    endcase
    return (r > 64'h7fffffff) ? 64'h7fffffff : r;
  endfunction
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    comparisons++;
    if (got !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, e, got);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic rdc(input string what, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(what, e, rd);
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    host_running <= 1'b0;
    src_run <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
  endtask
  task automatic start_host();
    @(posedge ref_clk);
    host_running <= 1'b1;
    t_run = cyc;
  endtask
  task automatic wait_valid(output int took);
    rd = 32'h0;
    while (rd[2] !== 1'b1 && cyc - t_run < 60000) bus(1'b0, pulse_meter_pkg::ADDR_STATUS, 0);
    took = cyc - t_run;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (90000) @(posedge ref_clk);
    miscompares++;
    give_verdict();
  end
  initial begin : main
    int n;
    int took;
    int h;
    int lim;
    longint e;
    do_reset();
    bus(1'b1, 6'h3c, 32'h5a5a5a5a);
    rdc("unmapped", 6'h3c, 32'h0);
    rdc("ctrl", pulse_meter_pkg::ADDR_CTRL, {29'h0, pulse_meter_pkg::SEL_RESET});
    rdc("upper", pulse_meter_pkg::ADDR_UPPER_PRESET, pulse_meter_pkg::UPPER_RESET);
    rdc("lower", pulse_meter_pkg::ADDR_LOWER_PRESET, pulse_meter_pkg::LOWER_RESET);
    rdc("mask", pulse_meter_pkg::ADDR_IRQ_MASK, {30'h0, pulse_meter_pkg::IRQ_MASK_RESET});
    rdc("status", pulse_meter_pkg::ADDR_STATUS, 32'h0);
    // counting modes: random edge bursts inside the first window
    for (int m = 3; m < 6; m++) begin
      do_reset();
      bus(1'b1, pulse_meter_pkg::ADDR_CTRL, m);
      bus(1'b1, pulse_meter_pkg::ADDR_IRQ_MASK, 32'h3);
      n = 1 + int'(rnd() % 32'd40);
      start_host();
      repeat (10) @(posedge ref_clk);
      src_half <= 32'd10;
      src_run <= 1'b1;
      repeat (n * 20) @(posedge ref_clk);
      src_run <= 1'b0;
      rdc("early", pulse_meter_pkg::ADDR_MEASURED, pulse_meter_pkg::INVALID_VALUE);
      wait_valid(took);
      chk("window", 32'd1, {31'h0, took >= wins[m] && took <= wins[m] + 8});
      exp_q.push_back(model(m, n, 0));
      e = exp_q.pop_front();
      rdc("count", pulse_meter_pkg::ADDR_MEASURED, e[31:0]);
      bus(1'b1, pulse_meter_pkg::ADDR_UPPER_PRESET, e[31:0] - 32'd1);
      repeat (3) @(posedge ref_clk);
      chk("no load", 32'd0, {31'h0, upper_exceeded});
      bus(1'b1, pulse_meter_pkg::ADDR_LOAD, 32'h1);
      bus(1'b1, pulse_meter_pkg::ADDR_LOAD, 32'h0);
      repeat (3) @(posedge ref_clk);
      chk("above", 32'd1, {31'h0, upper_exceeded});
      chk("no irq", 32'd0, {31'h0, irq});
      while (cyc - t_run < 2 * wins[m] + 6) @(posedge ref_clk);
      rdc("next", pulse_meter_pkg::ADDR_MEASURED, 32'h0);
      host_running <= 1'b0;
      src_run <= 1'b1;
      repeat (2 * wins[m]) @(posedge ref_clk);
      rdc("stopped", pulse_meter_pkg::ADDR_MEASURED, 32'h0);
      $display("test counting %0d done", m);
    end
    // timing modes: short interval saturates, long one reads zero, mid one divides
    for (int k = 0; k < 3; k++) begin
      h = (k == 1) ? 10500 : ((k == 2) ? 250 : 20);
      lim = (2 * wins[k] > 4 * h) ? 2 * wins[k] : 4 * h;
      do_reset();
      bus(1'b1, pulse_meter_pkg::ADDR_CTRL, k);
      bus(1'b1, pulse_meter_pkg::ADDR_IRQ_MASK, 32'h3);
      bus(1'b1, pulse_meter_pkg::ADDR_UPPER_PRESET, 32'd1000);
      bus(1'b1, pulse_meter_pkg::ADDR_LOWER_PRESET, 32'd5);
      bus(1'b1, pulse_meter_pkg::ADDR_LOAD, 32'h3);
      bus(1'b1, pulse_meter_pkg::ADDR_LOAD, 32'h0);
      start_host();
      src_half <= h;
      src_run <= 1'b1;
      wait_valid(took);
      chk("first", 32'd1, {31'h0, took <= lim + 12});
      e = model(k, 0, 2 * h);
      rdc("interval", pulse_meter_pkg::ADDR_MEASURED, e[31:0]);
      repeat (3) @(posedge ref_clk);
      chk("above", {31'h0, e > 1000}, {31'h0, upper_exceeded});
      chk("below", {31'h0, e < 5}, {31'h0, lower_undershot});
      chk("irq", 32'd1, {31'h0, irq});
      rdc("irq status", pulse_meter_pkg::ADDR_IRQ_STATUS, (e < 5) ? 32'h2 : 32'h1);
      bus(1'b1, pulse_meter_pkg::ADDR_IRQ_STATUS, 32'h3);
      repeat (3) @(posedge ref_clk);
      chk("irq clear", 32'd0, {31'h0, irq});
      // later windows keep the same value, past the next input edge too
      repeat (h + wins[k]) @(posedge ref_clk);
      rdc("steady", pulse_meter_pkg::ADDR_MEASURED, e[31:0]);
      $display("test timing %0d done", k);
    end
    give_verdict();
  end
endmodule
